// [mafm_pkg.sv]
// shared constants and types for the multi-alert fault monitor
`default_nettype none

package mafm_pkg;

   // ------------------------------------------------------------------
   // register indices
   // ------------------------------------------------------------------
   localparam logic [3:0]  IDX_CONFIG     = 4'h0;
   localparam logic [3:0]  IDX_ADC_CONFIG = 4'h1;
   localparam logic [3:0]  IDX_DIAG       = 4'h2;
   localparam logic [3:0]  IDX_CUR_LOW    = 4'h3;
   localparam logic [3:0]  IDX_CUR_HIGH   = 4'h4;
   localparam logic [3:0]  IDX_BUS_HIGH   = 4'h5;
   localparam logic [3:0]  IDX_BUS_LOW    = 4'h6;
   localparam logic [3:0]  IDX_HEAT       = 4'h7;
   localparam logic [3:0]  IDX_POWER      = 4'h8;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [15:0] RST_CUR_LOW    = 16'h8000;
   localparam logic [15:0] RST_CUR_HIGH   = 16'h7fff;
   localparam logic [15:0] RST_BUS_HIGH   = 16'h7fff;
   localparam logic [15:0] RST_BUS_LOW    = 16'h0000;
   localparam logic [15:0] RST_HEAT       = 16'hffff;
   localparam logic [15:0] RST_POWER      = 16'h7fff;
   localparam logic [15:0] ZERO16         = 16'h0000;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int          CFG_RST_BIT    = 15;
   localparam int          MODE_HI        = 1;
   localparam int          MODE_LO        = 0;
   localparam int          DG_POWER       = 0;
   localparam int          DG_HEAT        = 1;
   localparam int          DG_BUS_LOW     = 2;
   localparam int          DG_BUS_HIGH    = 3;
   localparam int          DG_CUR_LOW     = 4;
   localparam int          DG_CUR_HIGH    = 5;
   localparam int          DG_DONE        = 6;
   localparam int          DG_MEM_OK      = 7;
   localparam int          DG_MATH_OVF    = 8;
   localparam int          DG_ENERGY_OVF  = 9;
   localparam int          DG_CHARGE_OVF  = 10;
   localparam int          DG_AVG_CMP     = 12;
   localparam int          DG_POL_INV     = 13;
   localparam int          DG_DONE_ROUTE  = 14;
   localparam int          DG_LATCH_EN    = 15;

   // ------------------------------------------------------------------
   // mode codes and timing
   // ------------------------------------------------------------------
   localparam logic [1:0]  MODE_SHUTDOWN   = 2'h0;
   localparam logic [1:0]  MODE_TRIGGERED  = 2'h1;
   localparam logic [1:0]  MODE_CONTINUOUS = 2'h2;
   localparam int          SETTLE_TIME_US  = 300;
   localparam int          CLK_MHZ         = 40;
   localparam int          SETTLE_CYCLES   = SETTLE_TIME_US * CLK_MHZ;

   typedef enum logic [2:0] {
      ST_SHUTDOWN = 3'b001,
      ST_TRIG     = 3'b010,
      ST_CONT     = 3'b100
   } mafm_conv_e;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  idx;
      logic [15:0] wdata;
   } mafm_reg_req_s;

   typedef struct packed {
      logic [15:0] current;
      logic [15:0] bus;
      logic [15:0] heat;
      logic [15:0] power;
   } mafm_meas_s;

   typedef struct packed {
      logic        sample_valid;
      logic        conv_done;
      logic        math_ovf;
      logic        energy_ovf;
      logic        charge_ovf;
      logic        mem_ok;
   } mafm_events_s;

   typedef struct packed {
      logic        start;
      logic        abort;
      logic        run;
      logic        inputs_en;
      logic        timebase_en;
   } mafm_conv_ctrl_s;

   typedef struct packed {
      mafm_conv_e  cstate;
      logic [15:0] cur_low;
      logic [15:0] cur_high;
      logic [15:0] bus_high;
      logic [15:0] bus_low;
      logic [15:0] heat;
      logic [15:0] power;
      logic [1:0]  mode;
      logic        latch_en;
      logic        done_route;
      logic        avg_cmp;
      logic        pol_inv;
      logic [5:0]  limit_flags;
      logic        done_flag;
      logic        math_ovf;
      logic        energy_ovf;
      logic        charge_ovf;
      logic        mem_ok;
      logic        alert_hold;
      logic        alert_drive;
      logic [15:0] rdata;
      logic        conv_start;
      logic        conv_abort;
      logic [15:0] settle_cnt;
      logic        settled;
      logic [31:0] elapsed;
   } mafm_state_s;

endpackage

`default_nettype wire

// [mafm_monitor.sv]
// alert, diagnostic status and conversion mode control of the power monitor
//
// What this block does
// RL1: data_accurate rises only after about 300 us from power-up.
// RL2: in continuous mode, timebase clocks conversions and supplies elapsed time for energy and charge.
// RL3: current, bus, heat and power limits are compared against every result.
// RL4: diagnostic status shows one read-only flag per limit diagnostic.
// RL5: with latch enabled, alert stays asserted after conditions clear.
// RL6: reading diagnostic status releases the latched alert.
// RL7: with done routing enabled, alert also asserts on conversion completion.
// RL8: done flag sets on every completion regardless of routing.
// RL9: averaged compare uses averaged results, not each conversion.
// RL10: alert is open-drain, active low after reset; polarity bit inverts.
// RL11: arithmetic overflow sets a status flag.
// RL12: trim memory health bit reads one while memory is healthy.
// RL13: energy accumulator overflow sets a status flag.
// RL14: charge accumulator overflow sets a status flag.
// RL15: overflow and memory flags never drive the alert pin.
// RL16: done events and limit events share the alert pin when routed.
// RL17: shutdown stops conversions and disables input current.
// RL18: all registers stay readable and writable during shutdown.
// RL19: shutdown holds until a triggered or continuous mode is written.
// RL20: a triggered conversion finishes then returns to shutdown.
// RL21: power-on reset restores every register default.
// RL22: setting the config reset bit restores all register defaults.
// RL23: done flag clears on non-shutdown mode write or status read.
// RL24: a triggered or continuous mode write aborts and restarts the running conversion; a shutdown write only aborts it.
// RL25: alert is OR of limit flags and routed done, latched, then polarity.
`timescale 1ns/100ps
`default_nettype none

module mafm_monitor #(
   parameter int unsigned SETTLE_COUNT = mafm_pkg::SETTLE_CYCLES
) (
   input  wire logic                      core_clk,
   input  wire logic                      srst,
   input  wire mafm_pkg::mafm_reg_req_s   reg_req,
   output logic [15:0]                    reg_rdata,
   input  wire mafm_pkg::mafm_meas_s      meas,
   input  wire mafm_pkg::mafm_events_s    events,
   output mafm_pkg::mafm_conv_ctrl_s      conv_ctrl,
   output logic [31:0]                    elapsed_count,
   output logic                           data_accurate,
   output logic                           alert_o,
   output logic                           alert_oe
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   mafm_pkg::mafm_state_s st;
   mafm_pkg::mafm_state_s next_st;

   logic [5:0]  viol;
   logic        cmp_strobe;
   logic        wr_cfg;
   logic        wr_adc;
   logic        wr_diag;
   logic        rd_diag;
   logic        soft_rst;
   logic        mode_run;
   logic        any_alert;
   logic        asserted;
   logic [15:0] diag_word;
   logic [15:0] rd_mux;

   function automatic mafm_pkg::mafm_state_s reset_state();
      mafm_pkg::mafm_state_s r;
      r             = '0;
      r.cstate      = mafm_pkg::ST_SHUTDOWN;
      r.cur_low     = mafm_pkg::RST_CUR_LOW;
      r.cur_high    = mafm_pkg::RST_CUR_HIGH;
      r.bus_high    = mafm_pkg::RST_BUS_HIGH;
      r.bus_low     = mafm_pkg::RST_BUS_LOW;
      r.heat        = mafm_pkg::RST_HEAT;
      r.power       = mafm_pkg::RST_POWER;
      r.mode        = mafm_pkg::MODE_SHUTDOWN;
      return r;
   endfunction

   // ------------------------------------------------------------------
   // limit comparisons
   // ------------------------------------------------------------------
   always_comb begin
      viol                       = '0;
      // current is signed, the other quantities are positive only
      viol[mafm_pkg::DG_CUR_LOW]  = $signed(meas.current) < $signed(st.cur_low);  // RL3
      viol[mafm_pkg::DG_CUR_HIGH] = $signed(meas.current) > $signed(st.cur_high); // RL3
      viol[mafm_pkg::DG_BUS_HIGH] = meas.bus > st.bus_high;                       // RL3
      viol[mafm_pkg::DG_BUS_LOW]  = meas.bus < st.bus_low;                        // RL3
      viol[mafm_pkg::DG_HEAT]     = meas.heat > st.heat;                          // RL3
      viol[mafm_pkg::DG_POWER]    = meas.power > st.power;                        // RL3
      // averaged results only arrive with the completed conversion
      cmp_strobe = st.avg_cmp ? events.conv_done : events.sample_valid;           // RL9
   end

   // ------------------------------------------------------------------
   // register decode and status word
   // ------------------------------------------------------------------
   always_comb begin
      wr_cfg   = reg_req.wr && (reg_req.idx == mafm_pkg::IDX_CONFIG);
      wr_adc   = reg_req.wr && (reg_req.idx == mafm_pkg::IDX_ADC_CONFIG);
      wr_diag  = reg_req.wr && (reg_req.idx == mafm_pkg::IDX_DIAG);
      rd_diag  = reg_req.rd && (reg_req.idx == mafm_pkg::IDX_DIAG);
      soft_rst = wr_cfg && reg_req.wdata[mafm_pkg::CFG_RST_BIT];                  // RL22
      mode_run = (reg_req.wdata[mafm_pkg::MODE_HI:mafm_pkg::MODE_LO] == mafm_pkg::MODE_TRIGGERED) ||
                 (reg_req.wdata[mafm_pkg::MODE_HI:mafm_pkg::MODE_LO] == mafm_pkg::MODE_CONTINUOUS);

      diag_word                            = '0;
      diag_word[mafm_pkg::DG_CUR_HIGH:mafm_pkg::DG_POWER] = st.limit_flags;       // RL4
      diag_word[mafm_pkg::DG_DONE]         = st.done_flag;
      diag_word[mafm_pkg::DG_MEM_OK]       = st.mem_ok;                           // RL12
      diag_word[mafm_pkg::DG_MATH_OVF]     = st.math_ovf;                         // RL15
      diag_word[mafm_pkg::DG_ENERGY_OVF]   = st.energy_ovf;                       // RL15
      diag_word[mafm_pkg::DG_CHARGE_OVF]   = st.charge_ovf;                       // RL15
      diag_word[mafm_pkg::DG_AVG_CMP]      = st.avg_cmp;
      diag_word[mafm_pkg::DG_POL_INV]      = st.pol_inv;
      diag_word[mafm_pkg::DG_DONE_ROUTE]   = st.done_route;
      diag_word[mafm_pkg::DG_LATCH_EN]     = st.latch_en;

      // every index answers regardless of mode, shutdown included
      case (reg_req.idx)                                                          // RL18
         mafm_pkg::IDX_CONFIG:     rd_mux = mafm_pkg::ZERO16;
         mafm_pkg::IDX_ADC_CONFIG: rd_mux = {14'h0000, st.mode};
         mafm_pkg::IDX_DIAG:       rd_mux = diag_word;
         mafm_pkg::IDX_CUR_LOW:    rd_mux = st.cur_low;
         mafm_pkg::IDX_CUR_HIGH:   rd_mux = st.cur_high;
         mafm_pkg::IDX_BUS_HIGH:   rd_mux = st.bus_high;
         mafm_pkg::IDX_BUS_LOW:    rd_mux = st.bus_low;
         mafm_pkg::IDX_HEAT:       rd_mux = st.heat;
         mafm_pkg::IDX_POWER:      rd_mux = st.power;
         default:                  rd_mux = mafm_pkg::ZERO16;
      endcase
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      next_st            = st;
      next_st.conv_start = 1'b0;
      next_st.conv_abort = 1'b0;
      next_st.mem_ok     = events.mem_ok;                                         // RL12
      any_alert          = 1'b0;
      asserted           = 1'b0;

      if (reg_req.rd) begin
         next_st.rdata = rd_mux;
      end

      // threshold writes
      if (reg_req.wr) begin                                                       // RL18
         case (reg_req.idx)
            mafm_pkg::IDX_CUR_LOW:  next_st.cur_low  = reg_req.wdata;
            mafm_pkg::IDX_CUR_HIGH: next_st.cur_high = reg_req.wdata;
            mafm_pkg::IDX_BUS_HIGH: next_st.bus_high = reg_req.wdata;
            mafm_pkg::IDX_BUS_LOW:  next_st.bus_low  = reg_req.wdata;
            mafm_pkg::IDX_HEAT:     next_st.heat     = reg_req.wdata;
            mafm_pkg::IDX_POWER:    next_st.power    = reg_req.wdata;
            default: begin
            end
         endcase
      end

      if (wr_diag) begin
         next_st.avg_cmp    = reg_req.wdata[mafm_pkg::DG_AVG_CMP];
         next_st.pol_inv    = reg_req.wdata[mafm_pkg::DG_POL_INV];
         next_st.done_route = reg_req.wdata[mafm_pkg::DG_DONE_ROUTE];
         next_st.latch_en   = reg_req.wdata[mafm_pkg::DG_LATCH_EN];
      end

      // conversion mode control
      case (st.cstate)
         mafm_pkg::ST_SHUTDOWN: begin
            // stays here until a running mode is written
            if (wr_adc && mode_run) begin                                         // RL19
               next_st.conv_start = 1'b1;
               next_st.cstate     = (reg_req.wdata[mafm_pkg::MODE_HI:mafm_pkg::MODE_LO] ==
                                     mafm_pkg::MODE_CONTINUOUS) ? mafm_pkg::ST_CONT : mafm_pkg::ST_TRIG;
            end
         end
         mafm_pkg::ST_TRIG: begin
            if (wr_adc) begin
               next_st.conv_abort = 1'b1;                                         // RL24
               next_st.conv_start = mode_run;                                     // RL24
               next_st.cstate     = !mode_run ? mafm_pkg::ST_SHUTDOWN :           // RL17
                                    (reg_req.wdata[mafm_pkg::MODE_HI:mafm_pkg::MODE_LO] ==
                                     mafm_pkg::MODE_CONTINUOUS) ? mafm_pkg::ST_CONT : mafm_pkg::ST_TRIG;
            end else if (events.conv_done) begin
               next_st.cstate = mafm_pkg::ST_SHUTDOWN;                            // RL20
            end
         end
         mafm_pkg::ST_CONT: begin
            if (wr_adc) begin
               next_st.conv_abort = 1'b1;                                         // RL24
               next_st.conv_start = mode_run;                                     // RL24
               next_st.cstate     = !mode_run ? mafm_pkg::ST_SHUTDOWN :           // RL17
                                    (reg_req.wdata[mafm_pkg::MODE_HI:mafm_pkg::MODE_LO] ==
                                     mafm_pkg::MODE_CONTINUOUS) ? mafm_pkg::ST_CONT : mafm_pkg::ST_TRIG;
            end
         end
         default: begin
            next_st.cstate = mafm_pkg::ST_SHUTDOWN;
         end
      endcase

      if (wr_adc) begin
         next_st.mode = reg_req.wdata[mafm_pkg::MODE_HI:mafm_pkg::MODE_LO];
      end

      // elapsed time runs only in continuous mode, restarted by a mode write
      if (wr_adc) begin
         next_st.elapsed = '0;                                                    // RL2
      end else if (st.cstate == mafm_pkg::ST_CONT) begin
         next_st.elapsed = st.elapsed + 32'h0000_0001;                            // RL2
      end

      // done flag: completion sets, triggered or continuous mode write or status read clears, set wins
      if ((wr_adc && mode_run) || rd_diag) begin                                  // RL23
         next_st.done_flag = 1'b0;
      end
      if (events.conv_done) begin
         next_st.done_flag = 1'b1;                                                // RL8
      end

      // overflow flags are sticky until a status read, set wins
      if (rd_diag) begin
         next_st.math_ovf   = 1'b0;
         next_st.energy_ovf = 1'b0;
         next_st.charge_ovf = 1'b0;
      end
      if (events.math_ovf) begin
         next_st.math_ovf = 1'b1;                                                 // RL11
      end
      if (events.energy_ovf) begin
         next_st.energy_ovf = 1'b1;                                               // RL13
      end
      if (events.charge_ovf) begin
         next_st.charge_ovf = 1'b1;                                               // RL14
      end

      // limit flags: live when unlatched, sticky until status read when latched
      if (st.latch_en) begin
         if (rd_diag) begin
            next_st.limit_flags = '0;                                             // RL6
         end
         if (cmp_strobe) begin
            next_st.limit_flags = next_st.limit_flags | viol;                     // RL5
         end
      end else if (cmp_strobe) begin
         next_st.limit_flags = viol;                                              // RL3
      end

      // alert: overflow and memory flags deliberately left out
      any_alert = (|st.limit_flags) || (st.done_route && st.done_flag);           // RL25 RL16 RL7 RL15
      if (st.latch_en) begin
         // a status read drops the hold; flags set in the same cycle re-arm it
         next_st.alert_hold = (any_alert || st.alert_hold) && !rd_diag;           // RL5 RL6
      end else begin
         next_st.alert_hold = 1'b0;
      end
      asserted = any_alert || (st.latch_en && st.alert_hold);                     // RL25
      // pin pulled low when asserted, unless polarity is inverted
      next_st.alert_drive = asserted ^ st.pol_inv;                                // RL10

      // power-up settling
      if (!st.settled) begin
         if (st.settle_cnt >= SETTLE_COUNT[15:0] - 16'h0001) begin
            next_st.settled = 1'b1;                                               // RL1
         end else begin
            next_st.settle_cnt = st.settle_cnt + 16'h0001;                        // RL1
         end
      end

      if (soft_rst) begin
         next_st         = reset_state();                                         // RL22
         next_st.mem_ok  = events.mem_ok;
         next_st.settled = st.settled;
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st <= reset_state();                                                     // RL21
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   always_comb begin
      reg_rdata             = st.rdata;
      conv_ctrl.start       = st.conv_start;
      conv_ctrl.abort       = st.conv_abort;
      conv_ctrl.run         = st.cstate != mafm_pkg::ST_SHUTDOWN;                 // RL17
      conv_ctrl.inputs_en   = st.cstate != mafm_pkg::ST_SHUTDOWN;                 // RL17
      conv_ctrl.timebase_en = st.cstate == mafm_pkg::ST_CONT;                     // RL2
      elapsed_count         = st.elapsed;
      data_accurate         = st.settled;
      alert_o               = 1'b0;                                               // RL10
      alert_oe              = st.alert_drive;                                     // RL10
   end

endmodule

`default_nettype wire

// [mafm_host_model.sv]
// host side of the shared alert line with its pull-up
`timescale 1ns/100ps
`default_nettype none
module mafm_host_model (
   input  wire logic alert_o,
   input  wire logic alert_oe,
   output logic      alert_pin
);
   // released line floats up to the pull-up level
   assign alert_pin = alert_oe ? alert_o : 1'b1;
endmodule
`default_nettype wire

// [mafm_assertions.sv]
// port checks for the fault monitor
`timescale 1ns/100ps
`default_nettype none
module mafm_assertions #(parameter int unsigned SETTLE_COUNT = mafm_pkg::SETTLE_CYCLES) (
   input wire logic                      core_clk,
   input wire logic                      srst,
   input wire mafm_pkg::mafm_reg_req_s   reg_req,
   input wire logic [15:0]               reg_rdata,
   input wire mafm_pkg::mafm_events_s    events,
   input wire mafm_pkg::mafm_conv_ctrl_s conv_ctrl,
   input wire logic                      data_accurate,
   input wire logic                      alert_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic [15:0] age;
   wire         strobe  = events.sample_valid | events.conv_done;
   wire         touched = reg_req.wr | reg_req.rd;
   wire         mode_wr = reg_req.wr && reg_req.idx == mafm_pkg::IDX_ADC_CONFIG;
   wire         trig_wr = mode_wr && reg_req.wdata[1:0] == mafm_pkg::MODE_TRIGGERED;
   wire         cont_wr = mode_wr && reg_req.wdata[1:0] == mafm_pkg::MODE_CONTINUOUS;
   // cycles since power-on reset
   always_ff @(posedge core_clk) begin
      if (srst) age <= 16'h0000;
      else if (age != 16'hffff) age <= age + 16'h0001;
   end
   sequence s_stat_rd;
      reg_req.rd && !reg_req.wr && reg_req.idx == mafm_pkg::IDX_DIAG && !events.conv_done;
   endsequence
   sequence s_done;
      events.conv_done && !reg_req.wr;
   endsequence
   a_reset_state: assert property ($fell(srst) |-> !alert_oe && conv_ctrl == '0)
      else $error("outputs off defaults after reset");
   a_trig_start: assert property (trig_wr |=> conv_ctrl.start && conv_ctrl.run)
      else $error("triggered write did not start");
   a_cont_restart: assert property (cont_wr && conv_ctrl.run |=> conv_ctrl.abort && conv_ctrl.start)
      else $error("mode write did not restart");
   a_trig_return: assert property (events.conv_done && !reg_req.wr && conv_ctrl.run && !conv_ctrl.timebase_en
      |=> !conv_ctrl.run) else $error("triggered conversion did not stop");
   a_settle_time: assert property (data_accurate |-> age >= SETTLE_COUNT - 1)
      else $error("data accurate too early");
   a_done_set: assert property (s_done ##1 s_stat_rd |=> reg_rdata[mafm_pkg::DG_DONE])
      else $error("done flag missing");
   a_done_clear: assert property (s_stat_rd ##1 s_stat_rd |=> !reg_rdata[mafm_pkg::DG_DONE])
      else $error("done flag not cleared by read");
   a_alert_cause: assert property ($rose(alert_oe) |-> $past(strobe, 2) || $past(touched) || $past(touched, 2))
      else $error("alert moved without cause");
endmodule
bind mafm_monitor mafm_assertions #(.SETTLE_COUNT(SETTLE_COUNT)) mafm_assertions_i (
   .core_clk, .srst, .reg_req, .reg_rdata, .events, .conv_ctrl, .data_accurate, .alert_oe
);
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the fault monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                      core_clk, srst, rd_seen, acc, ao, oe, alert_pin;
   logic [15:0]               rdata;
   logic [31:0]               elapsed, rnd, note;
   logic [31:0]               exp_q[$];
   mafm_pkg::mafm_reg_req_s   req;
   mafm_pkg::mafm_meas_s      meas;
   mafm_pkg::mafm_events_s    ev;
   mafm_pkg::mafm_conv_ctrl_s cc;
   int                        fails, num_checks;
   logic [15:0]               dft [16] = '{16'h0000, 16'h0000, 16'h0080, mafm_pkg::RST_CUR_LOW,
      mafm_pkg::RST_CUR_HIGH, mafm_pkg::RST_BUS_HIGH, mafm_pkg::RST_BUS_LOW, mafm_pkg::RST_HEAT,
      mafm_pkg::RST_POWER, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0]               thr [6] = '{16'hff00, 16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100};
   logic [15:0]               fm [6]  = '{16'h0010, 16'h0020, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
   logic [63:0]               hit [6] = '{64'hfe00_0000_0000_0000, 64'h0200_0000_0000_0000,
      64'h0000_0200_0000_0000, 64'h0000_0010_0000_0000, 64'h0000_0000_0200_0000, 64'h0000_0000_0000_0200};
   mafm_monitor #(.SETTLE_COUNT(8)) mafm_monitor_i (
      .core_clk, .srst, .reg_req(req), .reg_rdata(rdata), .meas, .events(ev), .conv_ctrl(cc),
      .elapsed_count(elapsed), .data_accurate(acc), .alert_o(ao), .alert_oe(oe)
   );
   mafm_host_model mafm_host_model_i (.alert_o(ao), .alert_oe(oe), .alert_pin);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic flag(input string what, input logic e, input logic g);
      cmp(what, {15'h0000, e}, {15'h0000, g});
   endtask
   // one request cycle, launched at the falling edge
   task automatic cyc(input logic w, input logic r, input logic [3:0] i, input logic [15:0] d, input logic [5:0] e);
      @(negedge core_clk);
      req = '{w, r, i, d};
      ev  = e | 6'h01;
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(1'b0, 1'b0, 4'h0, 16'h0000, 6'h00);
   endtask
   task automatic pulse(input logic [5:0] e);
      cyc(1'b0, 1'b0, 4'h0, 16'h0000, e);
   endtask
   task automatic wr(input logic [3:0] i, input logic [15:0] d);
      cyc(1'b1, 1'b0, i, d, 6'h00);
   endtask
   task automatic rd(input logic [3:0] i, input logic [15:0] e, input logic [15:0] m);
      exp_q.push_back({m, e});
      cyc(1'b0, 1'b1, i, 16'h0000, 6'h00);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // read results checked against the oldest note
   always @(posedge core_clk) rd_seen <= req.rd & ~srst;
   always @(negedge core_clk) begin
      if (rd_seen === 1'b1 && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         cmp("read word", note[15:0], rdata & note[31:16]);
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      fails++;
      finish_test();
   end
   initial begin
      srst = 1'b1;
      req = '0;
      meas = '0;
      ev = 6'h01;
      rnd = 32'h9275;
      fails = 0;
      num_checks = 0;
      repeat (16) @(negedge core_clk);
      srst = 1'b0;
      flag("settled", 1'b0, acc);
      for (int i = 0; i < 16; i++) rd(4'(i), dft[i], 16'hffff);
      flag("alert pin", 1'b1, alert_pin);
      flag("settled", 1'b1, acc);
      for (int i = 3; i < 9; i++) begin
         rnd = lfsr(rnd);
         wr(4'(i), rnd[15:0]);
         rd(4'(i), rnd[15:0], 16'hffff);
      end
      wr(mafm_pkg::IDX_CONFIG, 16'h8000);
      for (int i = 3; i < 9; i++) rd(4'(i), dft[i], 16'hffff);
      for (int k = 0; k < 6; k++) begin
         wr(mafm_pkg::IDX_CONFIG, 16'h8000);
         wr(4'(k + 3), thr[k]);
         meas = hit[k];
         pulse(6'h20);
         idle(2);
         flag("alert pin", 1'b0, alert_pin);
         rd(mafm_pkg::IDX_DIAG, fm[k], 16'h003f);
      end
      meas = '0;
      pulse(6'h20);
      idle(2);
      flag("alert pin", 1'b1, alert_pin);
      wr(mafm_pkg::IDX_DIAG, 16'h8000);
      meas = hit[5];
      pulse(6'h20);
      idle(1);
      meas = '0;
      pulse(6'h20);
      idle(3);
      flag("alert pin", 1'b0, alert_pin);
      rd(mafm_pkg::IDX_DIAG, 16'h8001, 16'h803f);
      idle(2);
      flag("alert pin", 1'b1, alert_pin);
      wr(mafm_pkg::IDX_DIAG, 16'h2000);
      idle(2);
      flag("alert pin", 1'b0, alert_pin);
      meas = hit[5];
      pulse(6'h20);
      idle(2);
      flag("alert pin", 1'b1, alert_pin);
      meas = '0;
      wr(mafm_pkg::IDX_CONFIG, 16'h8000);
      pulse(6'h0e);
      idle(2);
      flag("alert pin", 1'b1, alert_pin);
      pulse(6'h10);
      rd(mafm_pkg::IDX_DIAG, 16'h07c0, 16'h07ff);
      rd(mafm_pkg::IDX_DIAG, 16'h0080, 16'h07ff);
      wr(mafm_pkg::IDX_DIAG, 16'h4000);
      pulse(6'h10);
      idle(2);
      flag("alert pin", 1'b0, alert_pin);
      wr(mafm_pkg::IDX_ADC_CONFIG, 16'h0002);
      wr(mafm_pkg::IDX_ADC_CONFIG, 16'h0002);
      idle(2);
      flag("alert pin", 1'b1, alert_pin);
      flag("timebase", 1'b1, cc.timebase_en);
      cmp("elapsed", 16'h0001, elapsed[15:0]);
      wr(mafm_pkg::IDX_ADC_CONFIG, 16'h0001);
      pulse(6'h10);
      idle(1);
      flag("running", 1'b0, cc.run);
      wr(mafm_pkg::IDX_ADC_CONFIG, 16'h0002);
      wr(mafm_pkg::IDX_ADC_CONFIG, 16'h0000);
      idle(3);
      flag("input current", 1'b0, cc.inputs_en);
      wr(mafm_pkg::IDX_DIAG, 16'h1000);
      meas = 64'h0000_0000_0000_8000;
      pulse(6'h20);
      idle(2);
      flag("alert pin", 1'b1, alert_pin);
      pulse(6'h10);
      idle(2);
      flag("alert pin", 1'b0, alert_pin);
      idle(2);
      finish_test();
   end
endmodule
`default_nettype wire
